// File: hw/pmc_misc_status.sv
// Misc control shadow register and aux status summary register
//
// Overview of operation
// - Bit 15 self-clears; selects full or partial write
// - Bits 14:12 pick shadow for 18h read
// - Bit 11: 1 counts receive, 0 transmit
// - Bit 9 keeps crossover automatic without negotiation
// - Bit 4 enables wire-speed feature, resets one
// - Bit 3 also accepts writes to address zero
// - Low three bits select shadow; reads 111
// - Status 15 shows negotiation complete
// - Bits 14:11 latch arbitration state entries
// - Bits 10:8 encode resolved speed and duplex
// - Mode shows manual choice without negotiation
// - Bit 7 latches parallel detection fault
// - Bit 6 shows partner remote fault
// - Bit 5 latches new page received
// - Bits 4,3 show partner negotiation abilities
// - Bit 2 shows link pass state
// - Bits 1,0 show resolved pause directions
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "pmc_map.svh"

module pmc_misc_status (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic [`PMC_ADDR_W-1:0] addr,
  input wire logic [15:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [15:0] rdData,
  // Management address check
  input wire logic [4:0] mgmtPhyAddr,
  input wire logic [4:0] ownPhyAddr,
  output logic mgmtWriteAccept,
  // PHY core status and control
  input wire pmc_pkg::pmc_link_status_t linkStatus,
  output pmc_pkg::pmc_ctrl_t ctrlOut,
  // Interrupt
  output logic irq
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [11:0] mergeCtrl(
    input logic [11:0] old,
    input logic [15:0] wd
  );
    logic [11:0] res;
    res = old;
    if (wd[`PMC_CTRL_WREN]) begin
      res = wd[14:3];
    end else begin
      res[11:9] = wd[14:12];
    end
    return res;
  endfunction : mergeCtrl

  function automatic logic [2:0] resolvedMode(
    input pmc_pkg::pmc_link_status_t s
  );
    // Negotiated value already reads 000 until a common mode exists
    return s.anEnabled ? s.highestCommonMode : s.manualMode;
  endfunction : resolvedMode

  // ************************************************************
  // Access decode
  // ************************************************************
  logic wrCtrl;
  logic wrMisc;
  logic rdStat;
  logic rdIrqStat;
  logic wrIrqMask;

  assign wrCtrl = wrEn && (addr == `PMC_CTRL_ADDR);
  // Only the misc control shadow lives here; other shadows elsewhere
  assign wrMisc = wrCtrl && (wrData[2:0] == `PMC_SHADOW_MISC);
  assign rdStat = rdEn && (addr == `PMC_STAT_ADDR);
  assign rdIrqStat = rdEn && (addr == `PMC_IRQ_STAT_ADDR);
  assign wrIrqMask = wrEn && (addr == `PMC_IRQ_MASK_ADDR);

  // ************************************************************
  // Control register
  // ************************************************************
  logic [11:0] ctrl;
  logic [11:0] next_ctrl;
  logic [2:0] shadowSel;
  logic [2:0] next_shadowSel;

  always_comb begin
    next_ctrl = ctrl;
    next_shadowSel = shadowSel;
    if (wrCtrl) begin
      next_shadowSel = wrData[2:0];
    end
    if (wrMisc) begin
      next_ctrl = mergeCtrl(ctrl, wrData);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `PMC_CTRL_RESET;
      shadowSel <= `PMC_SHADOW_SEL_RESET;
    end else begin
      ctrl <= next_ctrl;
      shadowSel <= next_shadowSel;
    end
  end

  logic [15:0] ctrlWord;
  // Write-enable bit never stores, so it always reads back 0
  assign ctrlWord = {1'b0, ctrl, `PMC_SHADOW_MISC};

  always_comb begin
    ctrlOut.readShadowSel =
      ctrlWord[`PMC_CTRL_SEL18_HI:`PMC_CTRL_SEL18_LO];
    ctrlOut.countRxPackets = ctrlWord[`PMC_CTRL_PKT_RX];
    ctrlOut.autoCrossoverEn = linkStatus.anEnabled
      || ctrlWord[`PMC_CTRL_FORCE_XOVER];
    ctrlOut.wireSpeedEn = ctrlWord[`PMC_CTRL_WIRESPEED];
    ctrlOut.allPhyAddrEn = ctrlWord[`PMC_CTRL_ALL_PHY];
  end

  assign mgmtWriteAccept = (mgmtPhyAddr == ownPhyAddr)
    || (ctrlWord[`PMC_CTRL_ALL_PHY]
        && (mgmtPhyAddr == `PMC_BCAST_PHY));

  // ************************************************************
  // Status latches
  // ************************************************************
  // Order: [5:2] state entries for bits 14:11, [1] fault, [0] page
  logic [5:0] latchLevel;
  logic [5:0] stLatch;
  logic [5:0] next_stLatch;

  assign latchLevel = {linkStatus.anState, linkStatus.parallelFault,
    linkStatus.pageReceived};

  always_comb begin
    // A read keeps a bit whose cause is still present, so set wins
    if (rdStat) begin
      next_stLatch = latchLevel;
    end else begin
      next_stLatch = stLatch | latchLevel;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stLatch <= 6'h00;
    end else begin
      stLatch <= next_stLatch;
    end
  end

  logic [15:0] statWord;
  always_comb begin
    statWord = 16'h0000;
    statWord[`PMC_ST_AN_DONE] = linkStatus.anComplete;
    statWord[`PMC_ST_ENTRY_HI:`PMC_ST_ENTRY_LO] = stLatch[5:2];
    statWord[`PMC_ST_MODE_HI:`PMC_ST_MODE_LO] =
      resolvedMode(linkStatus);
    statWord[`PMC_ST_PFAULT] = stLatch[1];
    statWord[`PMC_ST_RFAULT] = linkStatus.remoteFault;
    statWord[`PMC_ST_PAGE] = stLatch[0];
    statWord[`PMC_ST_LP_AN] = linkStatus.lpAnAble;
    statWord[`PMC_ST_LP_NP] = linkStatus.lpNextPage;
    statWord[`PMC_ST_LINK] = linkStatus.linkUp;
    statWord[`PMC_ST_PAUSE_RX] = linkStatus.pauseRx;
    statWord[`PMC_ST_PAUSE_TX] = linkStatus.pauseTx;
  end

  // ************************************************************
  // Interrupt status and mask
  // ************************************************************
  logic [5:0] prevLevel;
  logic prevLink;
  logic [`PMC_IRQ_W-1:0] irqEvent;
  logic [`PMC_IRQ_W-1:0] irqStat;
  logic [`PMC_IRQ_W-1:0] next_irqStat;
  logic [`PMC_IRQ_W-1:0] irqMask;
  logic [`PMC_IRQ_W-1:0] next_irqMask;

  // Rising edges only, so a held condition raises one interrupt
  logic [5:0] levelRise;
  assign levelRise = latchLevel & ~prevLevel;

  always_comb begin
    irqEvent = 7'h00;
    irqEvent[3:0] = levelRise[5:2];
    irqEvent[`PMC_IRQ_PFAULT] = levelRise[1];
    irqEvent[`PMC_IRQ_PAGE] = levelRise[0];
    irqEvent[`PMC_IRQ_LINK] = prevLink != linkStatus.linkUp;
  end

  always_comb begin
    next_irqMask = irqMask;
    if (wrIrqMask) begin
      next_irqMask = wrData[`PMC_IRQ_W-1:0];
    end
    if (rdIrqStat) begin
      next_irqStat = irqEvent;
    end else begin
      next_irqStat = irqStat | irqEvent;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prevLevel <= 6'h00;
      prevLink <= 1'b0;
      irqStat <= 7'h00;
      irqMask <= `PMC_IRQ_MASK_RESET;
    end else begin
      prevLevel <= latchLevel;
      prevLink <= linkStatus.linkUp;
      irqStat <= next_irqStat;
      irqMask <= next_irqMask;
    end
  end

  assign irq = |(irqStat & irqMask);

  // ************************************************************
  // Read data
  // ************************************************************
  logic [15:0] next_rdData;

  always_comb begin
    next_rdData = 16'h0000;
    if (rdEn) begin
      case (addr)
        `PMC_CTRL_ADDR: begin
          // Unimplemented shadows read as zero
          if (shadowSel == `PMC_SHADOW_MISC) begin
            next_rdData = ctrlWord;
          end
        end
        `PMC_STAT_ADDR: begin
          next_rdData = statWord;
        end
        `PMC_IRQ_STAT_ADDR: begin
          next_rdData = {9'h000, irqStat};
        end
        `PMC_IRQ_MASK_ADDR: begin
          next_rdData = {9'h000, irqMask};
        end
        default: begin
          next_rdData = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= 16'h0000;
    end else begin
      rdData <= next_rdData;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  a_wren_reads_zero: assert property (
    rdEn && addr == `PMC_CTRL_ADDR |=> !rdData[15])
    else $error("write enable bit read back as one");

  a_partial_write_keeps: assert property (
    wrMisc && !wrData[15] |=> $stable(ctrl[8:0])
      && ctrl[11:9] == $past(wrData[14:12]))
    else $error("partial write changed bits 11 to 3");

  a_full_write_loads: assert property (
    wrMisc && wrData[15] |=> ctrl == $past(wrData[14:3]))
    else $error("full write did not load bits 14 to 3");

  a_shadow18_select: assert property (
    wrMisc |=> ctrlOut.readShadowSel == $past(wrData[14:12]))
    else $error("read shadow selector not updated");

  a_pkt_dir_follow: assert property (
    wrMisc && wrData[15] |=> ctrlOut.countRxPackets == $past(wrData[11]))
    else $error("packet counter direction wrong");

  a_xover_forced: assert property (
    !linkStatus.anEnabled |->
      ctrlOut.autoCrossoverEn == ctrl[`PMC_CTRL_FORCE_XOVER - 3])
    else $error("crossover enable wrong without negotiation");

  a_all_phy_accept: assert property (
    ctrlOut.allPhyAddrEn && mgmtPhyAddr == 5'h00 |-> mgmtWriteAccept)
    else $error("broadcast phy address not accepted");

  a_misc_readback: assert property (
    rdEn && addr == `PMC_CTRL_ADDR && shadowSel == 3'h7
      |=> rdData[2:0] == 3'h7)
    else $error("misc control shadow code not read back");

  a_an_done_read: assert property (
    rdStat |=> rdData[15] == $past(linkStatus.anComplete))
    else $error("negotiation complete bit wrong");

  a_entry_latched: assert property (
    linkStatus.anState[3] |=> stLatch[5] ##1 (stLatch[5] || $past(rdStat)))
    else $error("state entry not latched");

  a_mode_manual: assert property (
    rdStat && !linkStatus.anEnabled
      |=> rdData[10:8] == $past(linkStatus.manualMode))
    else $error("manual mode not shown");

  a_fault_held: assert property (
    stLatch[1] && !rdStat |=> stLatch[1])
    else $error("parallel fault latch dropped without read");

  a_link_pause: assert property (
    rdStat |=> rdData[2:0] == $past({linkStatus.linkUp,
      linkStatus.pauseRx, linkStatus.pauseTx}))
    else $error("link or pause status wrong");

  a_stat_write_ignored: assert property (
    wrEn && addr == `PMC_STAT_ADDR && !rdStat && latchLevel == 6'h00
      |=> $stable(stLatch))
    else $error("status latches changed by a write");

  a_read_clears_stale: assert property (
    rdStat && !latchLevel[0] |=> !stLatch[0] || $past(latchLevel[0]))
    else $error("stale page latch not cleared by read");

  a_wirespeed_reset: assert property (
    $rose(rst_b) |-> ctrlOut.wireSpeedEn && !ctrlOut.allPhyAddrEn)
    else $error("control fields wrong after reset");

  a_xover_negotiated: assert property (
    linkStatus.anEnabled |-> ctrlOut.autoCrossoverEn)
    else $error("crossover not automatic under negotiation");

  a_shadow_other_keeps: assert property (
    wrCtrl && !wrMisc |=> $stable(ctrl))
    else $error("other shadow write changed control bits");

  a_entry_readout: assert property (
    rdStat |=> rdData[14:11] == $past(stLatch[5:2]))
    else $error("state entry flags not read back");

  a_mode_negotiated: assert property (
    rdStat && linkStatus.anEnabled
      |=> rdData[10:8] == $past(linkStatus.highestCommonMode))
    else $error("negotiated mode not shown");

  a_fault_set: assert property (
    linkStatus.parallelFault |=> stLatch[1])
    else $error("parallel fault not latched");

  a_remote_fault: assert property (
    rdStat |=> rdData[6] == $past(linkStatus.remoteFault))
    else $error("remote fault bit wrong");

  a_page_latched: assert property (
    linkStatus.pageReceived |=> stLatch[0])
    else $error("page received not latched");

  a_partner_ability: assert property (
    rdStat |=> rdData[4:3] == $past({linkStatus.lpAnAble,
      linkStatus.lpNextPage}))
    else $error("partner ability bits wrong");

endmodule : pmc_misc_status

// File: include/pmc_map.svh
// Register offsets, field positions, reset values of the misc/status block
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define PMC_ADDR_W 8
`define PMC_CTRL_ADDR 8'h30
`define PMC_STAT_ADDR 8'h32
`define PMC_IRQ_STAT_ADDR 8'h3c
`define PMC_IRQ_MASK_ADDR 8'h3e

// ************************************************************
// Control register fields
// ************************************************************
`define PMC_CTRL_WREN 15
`define PMC_CTRL_SEL18_HI 14
`define PMC_CTRL_SEL18_LO 12
`define PMC_CTRL_PKT_RX 11
`define PMC_CTRL_FORCE_XOVER 9
`define PMC_CTRL_WIRESPEED 4
`define PMC_CTRL_ALL_PHY 3
`define PMC_CTRL_STORE_LO 3
`define PMC_CTRL_RESET 12'h002
`define PMC_SHADOW_MISC 3'h7
`define PMC_SHADOW_SEL_RESET 3'h7
`define PMC_BCAST_PHY 5'h00

// ************************************************************
// Status register fields
// ************************************************************
`define PMC_ST_AN_DONE 15
`define PMC_ST_ENTRY_HI 14
`define PMC_ST_ENTRY_LO 11
`define PMC_ST_MODE_HI 10
`define PMC_ST_MODE_LO 8
`define PMC_ST_PFAULT 7
`define PMC_ST_RFAULT 6
`define PMC_ST_PAGE 5
`define PMC_ST_LP_AN 4
`define PMC_ST_LP_NP 3
`define PMC_ST_LINK 2
`define PMC_ST_PAUSE_RX 1
`define PMC_ST_PAUSE_TX 0

// ************************************************************
// Interrupt fields
// ************************************************************
`define PMC_IRQ_W 7
`define PMC_IRQ_PFAULT 4
`define PMC_IRQ_PAGE 5
`define PMC_IRQ_LINK 6
`define PMC_IRQ_MASK_RESET 7'h00

`endif

// File: include/pmc_pkg.sv
// Types shared by the misc control and aux status block
package pmc_pkg;

  // ************************************************************
  // Status sources from the PHY core
  // ************************************************************
  typedef struct packed {
    logic anEnabled;
    logic anComplete;
    logic [3:0] anState;
    logic [2:0] highestCommonMode;
    logic [2:0] manualMode;
    logic parallelFault;
    logic remoteFault;
    logic pageReceived;
    logic lpAnAble;
    logic lpNextPage;
    logic linkUp;
    logic pauseRx;
    logic pauseTx;
  } pmc_link_status_t;

  // ************************************************************
  // Control outputs to the PHY core
  // ************************************************************
  typedef struct packed {
    logic [2:0] readShadowSel;
    logic countRxPackets;
    logic autoCrossoverEn;
    logic wireSpeedEn;
    logic allPhyAddrEn;
  } pmc_ctrl_t;

endpackage : pmc_pkg

// File: bench/pmc_host_model.sv
// Management host model driving the register port of the block
`timescale 1ns/1ps
`include "pmc_map.svh"

module pmc_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [`PMC_ADDR_W-1:0] addr,
  output logic [15:0] wrData,
  output logic wrEn,
  output logic rdEn,
  input wire logic [15:0] rdData
);
  // Reserved control bits 10 and 8:5
  localparam logic [15:0] CtrlKeep = 16'hfa1f;

  initial begin
    addr = 8'h00;
    wrData = 16'h0000;
    wrEn = 1'b0;
    rdEn = 1'b0;
  end

  // ************************************************************
  // Bus cycles
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wrData <= (a == `PMC_CTRL_ADDR) ? (d & CtrlKeep) : d;
    wrEn <= 1'b1;
    @(posedge clk_sys);
    wrEn <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk_sys);
    rdEn <= 1'b0;
    #1;
    d = (a == `PMC_CTRL_ADDR) ? (rdData & CtrlKeep) : rdData;
  endtask : rd
endmodule : pmc_host_model

// File: bench/pmc_misc_status_bench.sv
// Self-checking bench for the misc control and aux status block
`timescale 1ns/1ps

module pmc_misc_status_bench;
  logic clk_sys;
  logic rst_b;
  logic [7:0] addr;
  logic [15:0] wrData;
  logic wrEn;
  logic rdEn;
  logic [15:0] rdData;
  logic [4:0] mgmtPhyAddr;
  logic [4:0] ownPhyAddr;
  logic mgmtWriteAccept;
  pmc_pkg::pmc_link_status_t linkStatus;
  pmc_pkg::pmc_ctrl_t ctrlOut;
  logic irq;
  int miscompares;
  int samplesChecked;
  logic [2:0] selCodes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};

  pmc_host_model u_host (.clk_sys(clk_sys), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData));

  pmc_misc_status u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .mgmtPhyAddr(mgmtPhyAddr), .ownPhyAddr(ownPhyAddr),
    .mgmtWriteAccept(mgmtWriteAccept), .linkStatus(linkStatus),
    .ctrlOut(ctrlOut), .irq(irq));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_host.rd(a, d);
    chk(d, exp);
  endtask : rdChk

  task automatic setLs(input logic [19:0] v);
    @(posedge clk_sys);
    linkStatus <= v;
  endtask : setLs

  task automatic conclude();
    $display("checks %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // Tests need well under a thousand cycles
  initial begin
    #100000;
    miscompares++;
    $display("BAD t=%0t watchdog expired", $time);
    conclude();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    miscompares = 0;
    samplesChecked = 0;
    rst_b = 1'b0;
    linkStatus = '0;
    mgmtPhyAddr = 5'h00;
    ownPhyAddr = 5'h05;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdChk(8'h30, 16'h0017);
    chk(16'(ctrlOut), 16'h0002);
    rdChk(8'h32, 16'h0000);
    u_host.wr(8'h30, 16'h8817);
    @(negedge clk_sys);
    chk(16'(ctrlOut), 16'h000a);
    rdChk(8'h30, 16'h0817);
    foreach (selCodes[i]) begin
      u_host.wr(8'h30, {1'b0, selCodes[i], 12'h007});
      @(negedge clk_sys);
      chk(16'(ctrlOut.readShadowSel), 16'(selCodes[i]));
    end
    rdChk(8'h30, 16'h7817);
    u_host.wr(8'h30, 16'h820f);
    rdChk(8'h30, 16'h020f);
    chk(16'(ctrlOut), 16'h0005);
    chk(16'(mgmtWriteAccept), 16'h0001);
    @(posedge clk_sys);
    mgmtPhyAddr <= 5'h03;
    @(negedge clk_sys);
    chk(16'(mgmtWriteAccept), 16'h0000);
    u_host.wr(8'h30, 16'h8007);
    @(posedge clk_sys);
    mgmtPhyAddr <= 5'h00;
    @(negedge clk_sys);
    chk(16'(ctrlOut), 16'h0000);
    chk(16'(mgmtWriteAccept), 16'h0000);
    // Selector other than 111 must leave the control bits alone
    u_host.wr(8'h30, 16'h8814);
    rdChk(8'h30, 16'h0000);
    u_host.wr(8'h30, 16'h0007);
    rdChk(8'h30, 16'h0007);
    // Status under negotiation, with one-cycle events
    u_host.wr(8'h32, 16'hffff);
    setLs(20'hfe8f6);
    setLs(20'hc2856);
    rdChk(8'h32, 16'hfdf6);
    rdChk(8'h32, 16'h8556);
    chk(16'(ctrlOut.autoCrossoverEn), 16'h0001);
    // Interrupt: masked, unmasked, cleared by read
    chk(16'(irq), 16'h0000);
    u_host.wr(8'h3e, 16'h007f);
    @(negedge clk_sys);
    chk(16'(irq), 16'h0001);
    rdChk(8'h3c, 16'h007f);
    @(negedge clk_sys);
    chk(16'(irq), 16'h0000);
    rdChk(8'h40, 16'h0000);
    // Manual mode; a fault still present survives the read
    setLs(20'h42adf);
    rdChk(8'h32, 16'h82df);
    rdChk(8'h32, 16'h82df);
    // Fault rise is interrupt bit 4
    chk(16'(irq), 16'h0001);
    rdChk(8'h3c, 16'h0010);
    conclude();
  end
endmodule : pmc_misc_status_bench
